/* File: verilog/csr_pkg.sv */
/*
 * Constants for the conversion signal routing block: register offsets,
 * field positions, reset values, route codes and bus answers.
 * Assumes a 32-bit AXI4-Lite register bus and a single 20 MHz core clock.
 */

package csr_pkg;

    // ==========================================================
    // Bus and widths
    // ==========================================================
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int DIV_W = 28;
    localparam int DIO_W = 14;
    localparam int NSIG = 3;

    // ==========================================================
    // Register offsets (byte addresses)
    // ==========================================================
    localparam logic [11:0] OFF_CLK1_GEN = 12'h320;
    localparam logic [11:0] OFF_CLK2_GEN = 12'h324;
    localparam logic [11:0] OFF_FRAME_GEN1 = 12'h32C;
    localparam logic [11:0] OFF_FRAME_GEN2 = 12'h330;
    localparam logic [11:0] OFF_ENABLES = 12'h33C;
    localparam logic [11:0] OFF_DRIVERS = 12'h340;
    localparam logic [11:0] OFF_SOURCES = 12'h344;
    localparam logic [11:0] OFF_STATUS = 12'h350;
    localparam logic [11:0] OFF_DIO_OE = 12'h360;
    localparam logic [11:0] OFF_DIO_OUT = 12'h364;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int EN_CLK1_BIT = 0;
    localparam int EN_CLK2_BIT = 1;
    localparam int EN_FRAME_BIT = 8;
    localparam int FRAME_SRC_BIT = 29;
    localparam int ST_CLK1_BIT = 28;
    localparam int ST_CLK2_BIT = 29;
    localparam int ST_RUN_BIT = 30;
    localparam int ST_DONE_BIT = 31;

    // ==========================================================
    // Route codes; upper bit clear means off or on-board
    // ==========================================================
    localparam logic [1:0] SEL_BACKPLANE = 2'h2;
    localparam logic [1:0] SEL_FRONT = 2'h3;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [DIV_W-1:0] DIV_RST = 28'hFFFFFFF;
    localparam logic [DIV_W-1:0] CNT_RST = 28'h0000000;
    localparam logic [2:0] EN_RST = 3'h0;
    localparam logic [5:0] ROUTE_RST = 6'h00;
    localparam logic [DIO_W-1:0] DIO_RST = 14'h0000;

    // ==========================================================
    // Bus answers
    // ==========================================================
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : csr_pkg

/* File: verilog/csr_gen_if.sv */
/*
 * Carrier between the routing top and one divider generator.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface csr_gen_if #(
    parameter int DIV_W = 28
);
    logic en;
    logic step;
    logic [DIV_W-1:0] div;
    logic clk;
    logic tick;

    modport gen (input en, input step, input div, output clk, output tick);
    modport ctl (output en, output step, output div, input clk, input tick);
endinterface : csr_gen_if

`default_nettype wire

/* File: verilog/csr_clock_gen.sv */
/*
 * Divider generator: counts steps modulo div+1, gives a square-ish
 * clock and a one-cycle tick at each wrap.
 * Assumes step is a one-cycle enable in the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module csr_clock_gen #(
    parameter int DIV_W = 28
) (
    input wire logic core_clk, // Core clock
    input wire logic rst_n,    // Async reset, active low
    csr_gen_if.gen bus         // Control and outputs
);

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic wrap;

    // ==========================================================
    // Next count
    // ==========================================================
    assign wrap = (cnt_q == bus.div);
    assign cnt_d = wrap ? '0 : cnt_q + 1'b1;

    // Counter held at zero while off so a restart is aligned
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!bus.en) begin
            cnt_q <= '0;
        end else if (bus.step) begin
            cnt_q <= cnt_d;
        end
    end

    // Output idles high when off; low for first half of a period
    // Limitation: divider zero gives no edges at core rate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.clk <= 1'b1;
        end else if (!bus.en) begin
            bus.clk <= 1'b1;
        end else if (bus.step) begin
            bus.clk <= (cnt_d > (bus.div >> 1));
        end
    end

    // One tick per completed period
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.tick <= 1'b0;
        end else begin
            bus.tick <= bus.en & bus.step & wrap;
        end
    end

endmodule : csr_clock_gen

`default_nettype wire

/* File: verilog/csr_routing_top.sv */
/*
 * Conversion signal routing: enables, output drivers and origin select
 * for two conversion clocks and a frame trigger, plus an AXI4-Lite slave.
 * Assumes all pin inputs are synchronous to core_clk and that the pads
 * resolve each output/enable pair into the shared wire.
 */
`timescale 1ns/1ps
`default_nettype none

module csr_routing_top #(
    parameter int DIV_W = csr_pkg::DIV_W,
    parameter int DIO_W = csr_pkg::DIO_W
) (
    input wire logic core_clk,                         // 20 MHz core clock
    input wire logic rst_n,                            // Async reset, active low
    input wire logic [csr_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid,                    // Write address valid
    output logic s_axi_awready,                        // Write address ready
    input wire logic [31:0] s_axi_wdata,               // Write data
    input wire logic [3:0] s_axi_wstrb,                // Byte enables
    input wire logic s_axi_wvalid,                     // Write data valid
    output logic s_axi_wready,                         // Write data ready
    output logic [1:0] s_axi_bresp,                    // Write response
    output logic s_axi_bvalid,                         // Write response valid
    input wire logic s_axi_bready,                     // Write response ready
    input wire logic [csr_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid,                    // Read address valid
    output logic s_axi_arready,                        // Read address ready
    output logic [31:0] s_axi_rdata,                   // Read data
    output logic [1:0] s_axi_rresp,                    // Read response
    output logic s_axi_rvalid,                         // Read data valid
    input wire logic s_axi_rready,                     // Read data ready
    input wire logic seq_mode_on,                      // Converters in sequencer mode
    input wire logic [2:0] bp_line_i,                  // Backplane lines in
    output logic [2:0] bp_line_o,                      // Backplane lines out
    output logic [2:0] bp_line_oe,                     // Backplane drive enables
    input wire logic [DIO_W-1:0] dio_i,                // Front pins in
    output logic [DIO_W-1:0] dio_o,                    // Front pins out
    output logic [DIO_W-1:0] dio_oe,                   // Front pin drive enables
    output logic conv_clk1_o,                          // Routed conversion clock 1
    output logic conv_clk2_o,                          // Routed conversion clock 2
    output logic frame_trig_o                          // Routed frame trigger
);

    // ==========================================================
    // Register state
    // ==========================================================
    logic [2:0] gen_on_q;            // clock 1, clock 2, frame
    logic [5:0] driver_select_q;
    logic [5:0] origin_q;
    logic [DIV_W-1:0] div_q [csr_pkg::NSIG];
    logic frame_src_q;
    logic [DIV_W-1:0] frame_trigger_count_q;
    logic [DIO_W-1:0] dio_out_en_q;
    logic [DIO_W-1:0] dio_out_val_q;

    // Frame sequencing state
    logic frame_on_prev_q;
    logic frame_done_q;
    logic [DIV_W-1:0] frame_left_q;

    // Bus state
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic wr_go;
    logic rd_go;
    logic [csr_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] rd_val;
    logic rd_hit;
    logic wr_hit;

    // Generator side
    logic [2:0] gen_val;
    logic [2:0] gen_step;
    logic [2:0] routed_q;
    logic [DIO_W-1:0] front_sel;
    logic [DIO_W-1:0] front_val;

    csr_gen_if #(.DIV_W(DIV_W)) gen_bus [csr_pkg::NSIG] ();

    // ==========================================================
    // Byte-lane merge for partial writes
    // ==========================================================
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    // ==========================================================
    // AXI4-Lite write channel
    // ==========================================================
    // Address and data taken together; simpler than skid buffering
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign wr_addr = {s_axi_awaddr[csr_pkg::ADDR_W-1:2], 2'b00};
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Decode of writable offsets
    always_comb begin
        case (wr_addr)
            csr_pkg::OFF_CLK1_GEN, csr_pkg::OFF_CLK2_GEN,
            csr_pkg::OFF_FRAME_GEN1, csr_pkg::OFF_FRAME_GEN2,
            csr_pkg::OFF_ENABLES, csr_pkg::OFF_DRIVERS,
            csr_pkg::OFF_SOURCES, csr_pkg::OFF_DIO_OE,
            csr_pkg::OFF_DIO_OUT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write response one cycle after the take
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= csr_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? csr_pkg::RESP_OKAY : csr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Control registers; one write starts all enabled generators
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_on_q <= csr_pkg::EN_RST;
            driver_select_q <= csr_pkg::ROUTE_RST;
            origin_q <= csr_pkg::ROUTE_RST;
            frame_src_q <= 1'b0;
            frame_trigger_count_q <= csr_pkg::CNT_RST;
            dio_out_en_q <= csr_pkg::DIO_RST;
            dio_out_val_q <= csr_pkg::DIO_RST;
            for (int i = 0; i < csr_pkg::NSIG; i++) begin
                div_q[i] <= csr_pkg::DIV_RST;
            end
        end else if (wr_go) begin
            case (wr_addr)
                csr_pkg::OFF_ENABLES: begin
                    logic [31:0] m;
                    m = merge({23'h0, gen_on_q[2], 6'h00, gen_on_q[1:0]},
                              s_axi_wdata, s_axi_wstrb);
                    gen_on_q <= {m[csr_pkg::EN_FRAME_BIT],
                                 m[csr_pkg::EN_CLK2_BIT],
                                 m[csr_pkg::EN_CLK1_BIT]};
                end
                csr_pkg::OFF_DRIVERS: begin
                    logic [31:0] m;
                    m = merge({26'h0, driver_select_q}, s_axi_wdata, s_axi_wstrb);
                    driver_select_q <= m[5:0];
                end
                csr_pkg::OFF_SOURCES: begin
                    logic [31:0] m;
                    m = merge({26'h0, origin_q}, s_axi_wdata, s_axi_wstrb);
                    origin_q <= m[5:0];
                end
                csr_pkg::OFF_CLK1_GEN: begin
                    logic [31:0] m;
                    m = merge({4'h0, div_q[0]}, s_axi_wdata, s_axi_wstrb);
                    div_q[0] <= m[DIV_W-1:0];
                end
                csr_pkg::OFF_CLK2_GEN: begin
                    logic [31:0] m;
                    m = merge({4'h0, div_q[1]}, s_axi_wdata, s_axi_wstrb);
                    div_q[1] <= m[DIV_W-1:0];
                end
                csr_pkg::OFF_FRAME_GEN1: begin
                    logic [31:0] m;
                    m = merge({2'h0, frame_src_q, 1'b0, div_q[2]},
                              s_axi_wdata, s_axi_wstrb);
                    div_q[2] <= m[DIV_W-1:0];
                    frame_src_q <= m[csr_pkg::FRAME_SRC_BIT];
                end
                csr_pkg::OFF_FRAME_GEN2: begin
                    logic [31:0] m;
                    m = merge({4'h0, frame_trigger_count_q}, s_axi_wdata, s_axi_wstrb);
                    frame_trigger_count_q <= m[DIV_W-1:0];
                end
                csr_pkg::OFF_DIO_OE: begin
                    logic [31:0] m;
                    m = merge({18'h0, dio_out_en_q}, s_axi_wdata, s_axi_wstrb);
                    dio_out_en_q <= m[DIO_W-1:0];
                end
                csr_pkg::OFF_DIO_OUT: begin
                    logic [31:0] m;
                    m = merge({18'h0, dio_out_val_q}, s_axi_wdata, s_axi_wstrb);
                    dio_out_val_q <= m[DIO_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    // ==========================================================
    assign rd_go = s_axi_arvalid & ~rvalid_q;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // Read mux; reserved bits read zero
    always_comb begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[csr_pkg::ADDR_W-1:2], 2'b00})
            csr_pkg::OFF_ENABLES: rd_val = {23'h0, gen_on_q[2], 6'h00, gen_on_q[1:0]};
            csr_pkg::OFF_DRIVERS: rd_val = {26'h0, driver_select_q};
            csr_pkg::OFF_SOURCES: rd_val = {26'h0, origin_q};
            csr_pkg::OFF_CLK1_GEN: rd_val = {4'h0, div_q[0]};
            csr_pkg::OFF_CLK2_GEN: rd_val = {4'h0, div_q[1]};
            csr_pkg::OFF_FRAME_GEN1: rd_val = {2'h0, frame_src_q, 1'b0, div_q[2]};
            csr_pkg::OFF_FRAME_GEN2: rd_val = {4'h0, frame_trigger_count_q};
            csr_pkg::OFF_DIO_OE: rd_val = {18'h0, dio_out_en_q};
            csr_pkg::OFF_DIO_OUT: rd_val = {18'h0, dio_out_val_q};
            csr_pkg::OFF_STATUS: begin
                rd_val[DIV_W-1:0] = frame_left_q;
                rd_val[csr_pkg::ST_CLK1_BIT] = gen_val[0];
                rd_val[csr_pkg::ST_CLK2_BIT] = gen_val[1];
                rd_val[csr_pkg::ST_RUN_BIT] = gen_bus[2].en;
                rd_val[csr_pkg::ST_DONE_BIT] = frame_done_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // Read data one cycle after the take, held until rready
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rresp_q <= csr_pkg::RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? csr_pkg::RESP_OKAY : csr_pkg::RESP_SLVERR;
            rdata_q <= rd_val;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // Frame trigger count sequencing
    // ==========================================================
    // Count loads on the enable's rising edge; later count writes wait
    // for the next restart, except that a zero count halts the countdown at once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_on_prev_q <= 1'b0;
            frame_done_q <= 1'b0;
            frame_left_q <= csr_pkg::CNT_RST;
        end else begin
            frame_on_prev_q <= gen_on_q[2];
            if (gen_on_q[2] && !frame_on_prev_q) begin
                frame_done_q <= 1'b0;
                frame_left_q <= frame_trigger_count_q;
            end else if (gen_bus[2].tick && frame_trigger_count_q != '0) begin
                frame_left_q <= frame_left_q - 1'b1;
                if (frame_left_q == {{(DIV_W-1){1'b0}}, 1'b1}) begin
                    frame_done_q <= 1'b1;
                end
            end
        end
    end

    // Frame steps on the chosen on-board clock generator's ticks
    assign gen_step[0] = 1'b1;
    assign gen_step[1] = 1'b1;
    assign gen_step[2] = frame_src_q ? gen_bus[1].tick : gen_bus[0].tick;

    // ==========================================================
    // Per-signal generators and routing
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < csr_pkg::NSIG; g++) begin : g_sig
            localparam int LSB = 2 * g;
            localparam int PIN = 2 * g; // Front pins 0, 2, 4

            // Zero count never sets done, so triggers run on
            assign gen_bus[g].en = (g == 2) ? (gen_on_q[g] & ~frame_done_q)
                                            : gen_on_q[g];
            assign gen_bus[g].step = gen_step[g];
            assign gen_bus[g].div = div_q[g];

            csr_clock_gen #(.DIV_W(DIV_W)) u_gen (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .bus(gen_bus[g].gen)
            );

            // Clocks carry the divided clock, frame carries its tick
            assign gen_val[g] = (g == 2) ? gen_bus[g].tick : gen_bus[g].clk;

            // Backplane driver on code 10
            assign bp_line_o[g] = gen_val[g];
            assign bp_line_oe[g] = (driver_select_q[LSB+1 -: 2] == csr_pkg::SEL_BACKPLANE);

            // Front pin request on code 11
            assign front_sel[PIN] = (driver_select_q[LSB+1 -: 2] == csr_pkg::SEL_FRONT);
            assign front_val[PIN] = gen_val[g];
            assign front_sel[PIN+1] = 1'b0;
            assign front_val[PIN+1] = 1'b0;

            // Origin select; manual-mode converters see idle levels
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    routed_q[g] <= (g != 2);
                end else if (!seq_mode_on) begin
                    routed_q[g] <= (g != 2);
                end else begin
                    case (origin_q[LSB+1 -: 2])
                        csr_pkg::SEL_BACKPLANE: routed_q[g] <= bp_line_i[g];
                        csr_pkg::SEL_FRONT: routed_q[g] <= dio_i[PIN];
                        default: routed_q[g] <= gen_val[g];
                    endcase
                end
            end
        end
        // Pins above those shared with the generators
        for (g = 2 * csr_pkg::NSIG; g < DIO_W; g++) begin : g_spare
            assign front_sel[g] = 1'b0;
            assign front_val[g] = 1'b0;
        end
    endgenerate

    // ==========================================================
    // Front pins: general output always wins
    // ==========================================================
    assign dio_oe = dio_out_en_q | front_sel;
    assign dio_o = (dio_out_en_q & dio_out_val_q) | (~dio_out_en_q & front_val);

    assign conv_clk1_o = routed_q[0];
    assign conv_clk2_o = routed_q[1];
    assign frame_trig_o = routed_q[2];

endmodule : csr_routing_top

`default_nettype wire

/* File: bench/csr_routing_asserts.sv */
/* Checker for csr_routing_top: bus answers and pin enables.
   Assumes one core clock and the async low reset of the top. */
`timescale 1ns/1ps
`default_nettype none
module csr_routing_asserts #(
    parameter int DIO_W = 14
) (
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic s_axi_awvalid, // Aw valid
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_awready, // Aw ready
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arvalid, // Ar valid
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready, // R ready
    input wire logic seq_mode_on, // Sequencer mode
    input wire logic [2:0] bp_line_oe, // Backplane enables
    input wire logic [DIO_W-1:0] dio_oe, // Front enables
    input wire logic conv_clk1_o, // Clock one
    input wire logic conv_clk2_o, // Clock two
    input wire logic frame_trig_o // Frame trigger
);
    // ==========================================================
    // Bus and pin properties
    logic wtake;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Write taken only with both halves offered
    assign wtake = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    chk_wr_answer: assert property (wtake |=> s_axi_bvalid) else $error("write unanswered");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_aw_pair: assert property (s_axi_awready |-> wtake) else $error("lone half taken");
    chk_rd_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read unanswered");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    chk_manual_idle: assert property (!seq_mode_on |=> conv_clk1_o && conv_clk2_o && !frame_trig_o)
        else $error("manual mode not idle");
    chk_oe_cause: assert property ($changed({dio_oe, bp_line_oe}) |-> $past(wtake) || $past(wtake, 2))
        else $error("enable moved without write");
    chk_reset_idle: assert property ($rose(rst_n) |-> bp_line_oe == 3'h0 && dio_oe == '0)
        else $error("drivers on after reset");
endmodule : csr_routing_asserts
bind csr_routing_top csr_routing_asserts #(.DIO_W(DIO_W)) u_chk (.core_clk, .rst_n,
    .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready, .seq_mode_on, .bp_line_oe, .dio_oe,
    .conv_clk1_o, .conv_clk2_o, .frame_trig_o);
`default_nettype wire

/* File: bench/csr_far_card.sv */
/* Far acquisition card sharing the conversion lines.
   Assumes the bench resolves its levels with the block's own. */
`timescale 1ns/1ps
`default_nettype none
module csr_far_card (
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic act, // High: master card
    output logic [2:0] bp_o, // Backplane levels
    output logic [13:0] fp_o // Front levels
);
    // ==========================================================
    // Own clocks
    logic [7:0] cnt_q;
    // Counter paces the far card's clocks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 8'h00;
        else cnt_q <= cnt_q + 8'h01;
    end
    // Target lets go; lines wander so stale values fail
    assign bp_o = act ? cnt_q[4:2] : {3{cnt_q[0]}};
    assign fp_o = act ? {cnt_q[5:0], cnt_q} : {14{cnt_q[0]}};
endmodule : csr_far_card
`default_nettype wire

/* File: bench/tb.sv */
/* Bench for csr_routing_top against a far card and a model.
   Assumes the checker binds itself to the top. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk, rst_n, seq_mode_on, act, s_axi_awvalid, s_axi_wvalid, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, conv_clk1_o, conv_clk2_o, frame_trig_o;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, got;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [2:0] bp_line_i, bp_line_o, bp_line_oe, far_bp, e;
    logic [13:0] dio_i, dio_o, dio_oe, far_fp;
    logic [11:0] ra[3] = '{12'h33C, 12'h340, 12'h344};
    int rm[3] = '{32'h103, 32'h3F, 32'h3F};
    int num_errors, check_count, seed, n, k, mdl[3];
    // ==========================================================
    // Wires resolved from every driver
    assign bp_line_i = bp_line_oe & bp_line_o | ~bp_line_oe & far_bp;
    assign dio_i = dio_oe & dio_o | ~dio_oe & far_fp;
    csr_routing_top dut (.*);
    csr_far_card far (.core_clk, .rst_n, .act, .bp_o(far_bp), .fp_o(far_fp));
    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do @(posedge core_clk); while (!s_axi_awready || !s_axi_wready);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge core_clk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge core_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        {got, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : rd
    // Counts triggers in k and clock-one highs in n
    task automatic watch;
        {k, n} = 0;
        repeat (48) begin
            @(posedge core_clk);
            @(negedge core_clk) chk(conv_clk2_o, conv_clk1_o);
            k += frame_trig_o;
            n += conv_clk1_o;
        end
    endtask : watch
    task automatic summarize;
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        seed = 32'h3f2f;
        {rst_n, seq_mode_on, act, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (20) @(posedge core_clk);
        {rst_n, seq_mode_on} <= 2'h3;
        for (k = 0; k < 3; k++) begin
            rd(ra[k]);
            chk(got, 0);
        end
        rd(12'hFFC);
        chk(rsp, csr_pkg::RESP_SLVERR);
        wr(12'hFFC, 32'h0);
        chk(rsp, csr_pkg::RESP_SLVERR);
        for (n = 0; n < 12; n++) begin
            mdl[n % 3] = $random(seed) & rm[n % 3];
            wr(ra[n % 3], mdl[n % 3]);
            rd(ra[n % 3]);
            chk(got, mdl[n % 3]);
        end
        for (k = 0; k < 3; k++) wr(ra[k], 0);
        // Every driver code with generators idle
        for (n = 0; n < 4; n++) begin
            wr(12'h340, n * 32'h15);
            chk({bp_line_o, bp_line_oe}, {3'h3, n == 2 ? 3'h7 : 3'h0});
            chk(dio_oe & 14'h15, n == 3 ? 14'h15 : 14'h0);
            if (n == 3) chk(dio_o & 14'h15, 14'h05);
        end
        wr(12'h360, 1);
        chk(dio_oe[0] && !dio_o[0], 1);
        wr(12'h360, 0);
        wr(12'h340, 0);
        // Far card masters every origin code
        act <= 1'b1;
        for (n = 0; n < 4; n++) begin
            wr(12'h344, n * 32'h15);
            repeat (4) begin
                @(negedge core_clk);
                e = n < 2 ? 3'h3 : n == 2 ? bp_line_i : {dio_i[4], dio_i[2], dio_i[0]};
                @(posedge core_clk);
                #1 chk({frame_trig_o, conv_clk2_o, conv_clk1_o}, e);
            end
        end
        wr(12'h344, 0);
        act <= 1'b0;
        wr(12'h320, 3);
        wr(12'h324, 3);
        wr(12'h32C, 32'h20000001);
        wr(12'h330, 2);
        wr(12'h33C, 32'h103);
        watch;
        chk(k, 2);
        chk(n, 24);
        wr(12'h33C, 3);
        wr(12'h330, 0);
        wr(12'h33C, 32'h103);
        watch;
        chk(k > 4, 1);
        @(posedge core_clk) seq_mode_on <= 1'b0;
        watch;
        chk(n - k, 48);
        @(posedge core_clk) seq_mode_on <= 1'b1;
        wr(12'h33C, 0);
        watch;
        chk(n - k, 48);
        summarize;
    end
    // Watchdog cuts a hang short
    initial begin
        #2000000;
        num_errors++;
        summarize;
    end
endmodule : tb
`default_nettype wire
